//--- la16_accumulator.sv
// Loadable add/subtract accumulator with AXI4-Lite control port
//
// Functional notes
// RL1 - Hold a 16-bit register, updated by adding or subtracting a 16-bit word.
// RL2 - Synchronous reset clears register and outputs, overriding every other input.
// RL3 - With reset and load inactive and enable low, register holds; a bus write of the CTRL software-load bit still copies the LOADVAL value in.
// RL4 - Asynchronous global reset forces register and outputs low.
// RL5 - Load stores load_value at the clock edge regardless of enable.
// RL6 - Op select high with enable adds operand_word into the register; the code skips the add while the CTRL freeze bit is set.
// RL7 - Op select low with enable subtracts operand_word from the register; the code skips the subtract while the CTRL freeze bit is set.
// RL8 - Unsigned range 0 to 65535; carry_out high when sum exceeds it.
// RL9 - When subtracting, carry_out is an active-low borrow.
// RL10 - carry_out is combinational from operand and register contents.
// RL11 - Users derive unsigned overflow as carry_out XOR op select.
// RL12 - Signed range -32768 to +32767; signed_overflow high when leaving it.
// RL13 - signed_overflow is combinational from operand and register contents.
// RL14 - Users ignore the flag that does not match their number format.
// RL15 - Users treat carry_out invalid during load, reset or disabled enable.
// RL16 - A low-order variant without carry_in exists for the least stage.
// RL17 - Carry_in adds when adding, acts as active-low borrow when subtracting.
// RL18 - Without carry_in, behave as zero carry or no borrow.
`timescale 1ns/1ps
module la16_accumulator
    import la16_pkg::*;
#(
    parameter int WIDTH        = ACC_WIDTH,
    parameter bit HAS_CARRY_IN = 1'b1
)
(
    input  wire logic                      ref_clk,
    input  wire logic                      arst_n,
    input  wire logic                      syncReset,
    input  wire logic                      loadEn,
    input  wire logic                      clkEn,
    input  wire logic                      opSelect,
    input  wire logic                      carryIn,
    input  wire logic [WIDTH-1:0]          loadValue,
    input  wire logic [WIDTH-1:0]          operandWord,
    output logic      [WIDTH-1:0]          accValue,
    output logic                           carryOut,
    output logic                           signedOverflow,
    input  wire logic [AXI_ADDR_WIDTH-1:0] awaddr,
    input  wire logic [2:0]                awprot,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [AXI_DATA_WIDTH-1:0] wdata,
    input  wire logic [AXI_STRB_WIDTH-1:0] wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic      [1:0]                bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    input  wire logic [AXI_ADDR_WIDTH-1:0] araddr,
    input  wire logic [2:0]                arprot,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic      [AXI_DATA_WIDTH-1:0] rdata,
    output logic      [1:0]                rresp,
    output logic                           rvalid,
    input  wire logic                      rready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0]          acc;
        logic                      run;
        logic                      freeze;
        logic [WIDTH-1:0]          swVal;
        logic                      awHeld;
        logic [AXI_ADDR_WIDTH-1:0] awAddr;
        logic                      wHeld;
        logic [AXI_DATA_WIDTH-1:0] wData;
        logic [AXI_STRB_WIDTH-1:0] wStrb;
        logic                      bValid;
        logic [1:0]                bResp;
        logic                      rValid;
        logic [AXI_DATA_WIDTH-1:0] rData;
        logic [1:0]                rResp;
    } la16_state_type;

    la16_state_type s_r;
    la16_state_type s_nxt;

    logic                      cinEff;
    logic [WIDTH-1:0]          sumWord;
    logic                      carryRaw;
    logic                      ovfRaw;
    logic                      flagGate;
    logic                      awTake;
    logic                      wTake;
    logic                      arTake;
    logic                      wrCommit;
    logic [AXI_ADDR_WIDTH-1:0] wrAddr;
    logic [AXI_DATA_WIDTH-1:0] wrData;
    logic [AXI_STRB_WIDTH-1:0] wrStrb;
    la16_reg_type              wrSel;
    logic                      swLoad;
    logic                      stepEn;
    logic [AXI_DATA_WIDTH-1:0] statusWord;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic la16_reg_type decodeReg(input logic [AXI_ADDR_WIDTH-1:0] a);
        if (a == CTRL_OFS)
            return REG_CTRL;
        else if (a == STATUS_OFS)
            return REG_STATUS;
        else if (a == LOADVAL_OFS)
            return REG_LOADVAL;
        else
            return REG_NONE;
    endfunction : decodeReg

    function automatic logic [AXI_DATA_WIDTH-1:0] mergeBytes(
        input logic [AXI_DATA_WIDTH-1:0] oldVal,
        input logic [AXI_DATA_WIDTH-1:0] newVal,
        input logic [AXI_STRB_WIDTH-1:0] strb);
        logic [AXI_DATA_WIDTH-1:0] res;
        res = oldVal;
        for (int i = 0; i < AXI_STRB_WIDTH; i++)
        begin
            if (strb[i])
                res[8*i +: 8] = newVal[8*i +: 8];
        end
        return res;
    endfunction : mergeBytes

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    // RL16 RL18 no carry_in: zero carry adding, no borrow subtracting
    assign cinEff = HAS_CARRY_IN ? carryIn : ~opSelect;

    // RL17 carry_in enters the chain in both modes
    la16_addsub #(
        .WIDTH          (WIDTH)
    ) u_addsub (
        .accIn          (s_r.acc),
        .operandWord    (operandWord),
        .opSelect       (opSelect),
        .carryIn        (cinEff),
        .sumOut         (sumWord),
        .carryOut       (carryRaw),
        .signedOverflow (ovfRaw)
    );

    // RL2 flags read zero during synchronous reset
    assign flagGate       = s_r.run & ~syncReset;
    // RL10 carry flag is combinational, usable as next carry_in
    assign carryOut       = flagGate & carryRaw;
    // RL13 overflow flag is combinational too
    assign signedOverflow = flagGate & ovfRaw;
    assign accValue       = s_r.acc;

    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    // Address and data are each held until the other arrives, and neither
    // is accepted while a response is pending, so at most one write is in flight
    assign awready  = ~s_r.awHeld & ~s_r.bValid;
    assign wready   = ~s_r.wHeld & ~s_r.bValid;
    assign arready  = ~s_r.rValid;
    assign awTake   = awvalid & awready;
    assign wTake    = wvalid & wready;
    assign arTake   = arvalid & arready;
    assign wrAddr   = s_r.awHeld ? s_r.awAddr : awaddr;
    assign wrData   = s_r.wHeld ? s_r.wData : wdata;
    assign wrStrb   = s_r.wHeld ? s_r.wStrb : wstrb;
    assign wrCommit = (s_r.awHeld | awTake) & (s_r.wHeld | wTake);
    assign wrSel    = decodeReg(wrAddr);
    assign swLoad   = wrCommit & (wrSel == REG_CTRL) & wrStrb[0]
                    & wrData[CTRL_SWLOAD_BIT];
    assign stepEn   = clkEn & ~s_r.freeze;

    assign bvalid   = s_r.bValid;
    assign bresp    = s_r.bResp;
    assign rvalid   = s_r.rValid;
    assign rdata    = s_r.rData;
    assign rresp    = s_r.rResp;

    always_comb
    begin
        statusWord                 = '0;
        statusWord[WIDTH-1:0]      = s_r.acc;
        statusWord[STAT_CARRY_BIT] = carryOut;
        statusWord[STAT_OVF_BIT]   = signedOverflow;
        statusWord[STAT_UOVF_BIT]  = carryOut ^ opSelect;
        statusWord[STAT_RUN_BIT]   = s_r.run;
        statusWord[STAT_OPSEL_BIT] = opSelect;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [AXI_DATA_WIDTH-1:0] merged;
        merged = '0;
        s_nxt  = s_r;
        s_nxt.run = 1'b1;

        if (syncReset)
        begin
            // RL2 synchronous reset has top priority
            s_nxt.acc = '0;
        end
        else if (loadEn)
        begin
            // RL5 load overrides the enable
            s_nxt.acc = loadValue;
        end
        else if (swLoad)
        begin
            s_nxt.acc = s_r.swVal;
        end
        else if (stepEn)
        begin
            // RL1 add or subtract into the register
            s_nxt.acc = sumWord;
        end
        // RL3 otherwise the register keeps its value

        if (awTake)
        begin
            s_nxt.awHeld = 1'b1;
            s_nxt.awAddr = awaddr;
        end
        if (wTake)
        begin
            s_nxt.wHeld = 1'b1;
            s_nxt.wData = wdata;
            s_nxt.wStrb = wstrb;
        end
        if (s_r.bValid && bready)
            s_nxt.bValid = 1'b0;

        if (wrCommit)
        begin
            s_nxt.awHeld = 1'b0;
            s_nxt.wHeld  = 1'b0;
            s_nxt.bValid = 1'b1;
            s_nxt.bResp  = RESP_OKAY;
            unique case (wrSel)
                REG_CTRL:
                begin
                    if (wrStrb[0])
                        s_nxt.freeze = wrData[CTRL_FREEZE_BIT];
                end
                REG_LOADVAL:
                begin
                    merged = mergeBytes({{(AXI_DATA_WIDTH-WIDTH){1'b0}}, s_r.swVal},
                                        wrData, wrStrb);
                    s_nxt.swVal = merged[WIDTH-1:0];
                end
                REG_STATUS:
                begin
                    s_nxt.bResp = RESP_OKAY;
                end
                REG_NONE:
                begin
                    s_nxt.bResp = RESP_SLVERR;
                end
            endcase
        end

        if (s_r.rValid && rready)
            s_nxt.rValid = 1'b0;
        if (arTake)
        begin
            s_nxt.rValid = 1'b1;
            s_nxt.rResp  = RESP_OKAY;
            unique case (decodeReg(araddr))
                REG_CTRL:
                begin
                    s_nxt.rData = '0;
                    s_nxt.rData[CTRL_FREEZE_BIT] = s_r.freeze;
                end
                REG_STATUS:
                begin
                    s_nxt.rData = statusWord;
                end
                REG_LOADVAL:
                begin
                    s_nxt.rData = {{(AXI_DATA_WIDTH-WIDTH){1'b0}}, s_r.swVal};
                end
                REG_NONE:
                begin
                    s_nxt.rData = '0;
                    s_nxt.rResp = RESP_SLVERR;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // RL4 global reset forces the register and flags low
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r        <= '0;
            s_r.acc    <= ACC_RST;
            s_r.freeze <= FREEZE_RST;
            s_r.swVal  <= LOADVAL_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic             pinStep;
    logic [WIDTH:0]   refAdd;
    logic [WIDTH:0]   refSub;
    logic [WIDTH:0]   refSgn;
    logic [WIDTH-1:0] opEffRef;

    assign pinStep  = ~syncReset & ~loadEn & ~swLoad & stepEn;
    assign opEffRef = opSelect ? operandWord : ~operandWord;
    assign refAdd   = {1'b0, s_r.acc} + {1'b0, operandWord}
                    + {{WIDTH{1'b0}}, cinEff};
    assign refSub   = {1'b0, s_r.acc} + {1'b0, ~operandWord}
                    + {{WIDTH{1'b0}}, cinEff};
    assign refSgn   = {s_r.acc[WIDTH-1], s_r.acc} + {opEffRef[WIDTH-1], opEffRef}
                    + {{WIDTH{1'b0}}, cinEff};

    // RL2 reset clears the register next edge
    AST_SYNC_CLEAR: assert property (  // RL2
        @(posedge ref_clk) disable iff (!arst_n)
        syncReset |=> (accValue == '0))
        else $error("accumulator not cleared by synchronous reset");

    // RL2 flags are low while reset is high
    AST_FLAGS_IN_RESET: assert property (  // RL2
        @(posedge ref_clk) disable iff (!arst_n)
        syncReset |-> (!carryOut && !signedOverflow))
        else $error("flag high during synchronous reset");

    // RL3 idle edges leave the register alone
    AST_HOLD: assert property (  // RL3
        @(posedge ref_clk) disable iff (!arst_n)
        (!syncReset && !loadEn && !swLoad && !clkEn) |=> $stable(accValue))
        else $error("accumulator changed with enable low");

    // RL5 load wins over enable
    AST_LOAD: assert property (  // RL5
        @(posedge ref_clk) disable iff (!arst_n)
        (!syncReset && loadEn) |=> (accValue == $past(loadValue)))
        else $error("load value not stored");

    // RL6 enabled add stores the sum
    AST_ADD: assert property (  // RL6
        @(posedge ref_clk) disable iff (!arst_n)
        (pinStep && opSelect) |=> (accValue == $past(refAdd[WIDTH-1:0])))
        else $error("add result wrong");

    // RL7 enabled subtract stores the difference
    AST_SUB: assert property (  // RL7
        @(posedge ref_clk) disable iff (!arst_n)
        (pinStep && !opSelect) |=> (accValue == $past(refSub[WIDTH-1:0])))
        else $error("subtract result wrong");

    // RL8 carry marks an unsigned sum beyond range
    AST_CARRY: assert property (  // RL8
        @(posedge ref_clk) disable iff (!arst_n)
        (s_r.run && !syncReset && opSelect) |-> (carryOut == refAdd[WIDTH]))
        else $error("carry out wrong in add mode");

    // RL9 active-low borrow when subtracting
    AST_BORROW: assert property (  // RL9
        @(posedge ref_clk) disable iff (!arst_n)
        (s_r.run && !syncReset && !opSelect) |-> (carryOut == refSub[WIDTH]))
        else $error("borrow out wrong in subtract mode");

    // RL12 signed overflow flags a result outside signed range
    AST_SIGNED_OVF: assert property (  // RL12
        @(posedge ref_clk) disable iff (!arst_n)
        (s_r.run && !syncReset) |-> (signedOverflow == (refSgn[WIDTH] ^ refSgn[WIDTH-1])))
        else $error("signed overflow wrong");

    // RL16 without carry_in a plain add carries no extra one
    AST_NO_CIN: assert property (  // RL16
        @(posedge ref_clk) disable iff (!arst_n)
        (!HAS_CARRY_IN && pinStep && opSelect)
            |=> (accValue == $past(s_r.acc + operandWord)))
        else $error("low-order variant added a carry");

endmodule : la16_accumulator

//--- la16_addsub.sv
// Ripple-carry add/subtract stage with carry and signed overflow
`timescale 1ns/1ps
module la16_addsub
    import la16_pkg::*;
#(
    parameter int WIDTH = ACC_WIDTH
)
(
    input  wire logic [WIDTH-1:0] accIn,
    input  wire logic [WIDTH-1:0] operandWord,
    input  wire logic             opSelect,
    input  wire logic             carryIn,
    output logic      [WIDTH-1:0] sumOut,
    output logic                  carryOut,
    output logic                  signedOverflow
);

    logic [WIDTH:0]   chain;
    logic [WIDTH-1:0] operandEff;

    // ------------------------------------------------------------
    // Operand conditioning
    // ------------------------------------------------------------
    // Subtract is add of the complement; carryIn then acts as an
    // active-low borrow, so one chain serves both modes
    // RL6 RL7 mode picks true or complemented word
    assign operandEff = opSelect ? operandWord : ~operandWord;
    assign chain[0]   = carryIn;

    // ------------------------------------------------------------
    // Full-adder chain
    // ------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        assign sumOut[i]  = accIn[i] ^ operandEff[i] ^ chain[i];
        assign chain[i+1] = (accIn[i] & operandEff[i])
                          | (chain[i] & (accIn[i] ^ operandEff[i]));
    end

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    // RL8 RL9 top carry, low means borrow when subtracting
    assign carryOut       = chain[WIDTH];
    // RL12 sign carries disagree on signed overflow
    assign signedOverflow = chain[WIDTH] ^ chain[WIDTH-1];

endmodule : la16_addsub

//--- la16_pkg.sv
// Shared constants for the loadable 16-bit accumulator
package la16_pkg;

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    localparam int ACC_WIDTH      = 16;
    localparam int AXI_ADDR_WIDTH = 4;
    localparam int AXI_DATA_WIDTH = 32;
    localparam int AXI_STRB_WIDTH = 4;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [AXI_ADDR_WIDTH-1:0] CTRL_OFS    = 4'h0;
    localparam logic [AXI_ADDR_WIDTH-1:0] STATUS_OFS  = 4'h4;
    localparam logic [AXI_ADDR_WIDTH-1:0] LOADVAL_OFS = 4'h8;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_FREEZE_BIT  = 0;
    localparam int CTRL_SWLOAD_BIT  = 1;
    localparam int STAT_CARRY_BIT   = 16;
    localparam int STAT_OVF_BIT     = 17;
    localparam int STAT_UOVF_BIT    = 18;
    localparam int STAT_RUN_BIT     = 19;
    localparam int STAT_OPSEL_BIT   = 20;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic                 FREEZE_RST  = 1'b0;
    localparam logic [ACC_WIDTH-1:0] LOADVAL_RST = 16'h0000;
    localparam logic [ACC_WIDTH-1:0] ACC_RST     = 16'h0000;

    // ------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        REG_CTRL,
        REG_STATUS,
        REG_LOADVAL,
        REG_NONE
    } la16_reg_type;

endpackage : la16_pkg

//--- la16_stage_model.sv
// High-order cascade stage model fed by the accumulator carry output
`timescale 1ns/1ps
module la16_stage_model
(
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        syncReset,
    input  wire logic        loadEn,
    input  wire logic        clkEn,
    input  wire logic        opSelect,
    input  wire logic        lowCarry,
    output logic      [15:0] hiWord,
    output logic             unsignedOvf
);
    // ----------------
    // Upper word
    // ----------------
    // carry ripples up, borrow is active low
    // carry is used whenever clkEn is high and neither syncReset nor loadEn is
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            hiWord <= '0;
        else if (syncReset || loadEn)
            hiWord <= '0;
        else if (clkEn && opSelect)
            hiWord <= hiWord + {15'h0, lowCarry};
        else if (clkEn)
            hiWord <= hiWord - {15'h0, !lowCarry};
    end

    // unsigned overflow, signed flag deliberately unused
    assign unsignedOvf = lowCarry ^ opSelect;
endmodule : la16_stage_model

//--- test_loadable_accumulator_16bit.sv
// Self-checking bench for the loadable 16-bit accumulator
`timescale 1ns/1ps
module test_loadable_accumulator_16bit import la16_pkg::*;;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        syncReset = 1'b0, loadEn = 1'b0, clkEn = 1'b0;
    logic        opSelect = 1'b0, carryIn = 1'b0;
    logic [15:0] loadValue = '0, operandWord = '0, accValue, hiWord, loAcc;
    logic        carryOut, signedOverflow, unsignedOvf, loCarry;
    logic [3:0]  awaddr = '0, araddr = '0, wstrb = 4'hF;
    logic [31:0] wdata = '0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    int          err_count = 0, tests_run = 0, cycles = 0;

    la16_accumulator #(.WIDTH(ACC_WIDTH), .HAS_CARRY_IN(1'b1)) i_la16_accumulator (
        .ref_clk, .arst_n, .syncReset, .loadEn, .clkEn, .opSelect, .carryIn,
        .loadValue, .operandWord, .accValue, .carryOut, .signedOverflow,
        .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready);
    // Low-order variant shares the controls; its carry input must be ignored
    la16_accumulator #(.WIDTH(ACC_WIDTH), .HAS_CARRY_IN(1'b0)) i_la16_accumulator_lo (
        .ref_clk, .arst_n, .syncReset, .loadEn, .clkEn, .opSelect, .carryIn,
        .loadValue, .operandWord, .accValue(loAcc), .carryOut(loCarry), .signedOverflow(),
        .awaddr('0), .awprot(3'h0), .awvalid(1'b0), .awready(), .wdata('0), .wstrb('0),
        .wvalid(1'b0), .wready(), .bresp(), .bvalid(), .bready(1'b0), .araddr('0),
        .arprot(3'h0), .arvalid(1'b0), .arready(), .rdata(), .rresp(), .rvalid(),
        .rready(1'b0));
    la16_stage_model i_la16_stage_model (.ref_clk, .arst_n, .syncReset, .loadEn,
        .clkEn, .opSelect, .lowCarry(carryOut), .hiWord, .unsignedOvf);

    always #20 ref_clk = ~ref_clk;

    // Whole run needs under a hundred cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            err_count++;
            print_verdict();
        end
    end

    // ----------------
    // Shared tasks
    // ----------------
    task automatic print_verdict();
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // Control bits in order: syncReset, loadEn, clkEn, opSelect, carryIn
    task automatic drive(input logic [4:0] c, input logic [15:0] lv, input logic [15:0] ow);
        @(posedge ref_clk);
        {syncReset, loadEn, clkEn, opSelect, carryIn} <= c;
        loadValue   <= lv;
        operandWord <= ow;
        @(negedge ref_clk);
    endtask : drive

    task automatic axiWr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b0;
        w  = 1'b0;
        @(posedge ref_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge ref_clk);
            if (!aw && awready)
            begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready)
            begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask : axiWr

    task automatic axiRd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge ref_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (!rvalid);
        rready <= 1'b0;
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, er});
    endtask : axiRd

    // ----------------
    // Scenarios
    // ----------------
    task automatic t_add();
        drive(5'h0B, 16'hFFFF, 16'h0000);
        drive(5'h07, 16'h0000, 16'h0001);
        chk({16'h0000, accValue}, 32'h0000_FFFF);
        chk({30'h0, carryOut, signedOverflow}, 32'h0000_0002);
        chk({31'h0, loCarry}, 32'h0000_0001);
        drive(5'h03, 16'h0000, 16'h0001);
        chk({16'h0000, accValue}, 32'h0000_0001);
        chk({16'h0000, loAcc}, 32'h0000_0000);
        chk({16'h0000, hiWord}, 32'h0000_0001);
        drive(5'h03, 16'h0000, 16'h0001);
        chk({16'h0000, accValue}, 32'h0000_0001);
    endtask : t_add

    task automatic t_sub();
        drive(5'h08, 16'h8000, 16'h0000);
        drive(5'h05, 16'h0000, 16'h0001);
        chk({16'h0000, accValue}, 32'h0000_8000);
        chk({30'h0, carryOut, signedOverflow}, 32'h0000_0003);
        chk({31'h0, unsignedOvf}, 32'h0000_0001);
        drive(5'h0D, 16'h0000, 16'h0000);
        chk({16'h0000, accValue}, 32'h0000_7FFF);
        drive(5'h04, 16'h0000, 16'h0000);
        chk({16'h0000, accValue}, 32'h0000_0000);
        chk({30'h0, carryOut, signedOverflow}, 32'h0000_0000);
        chk({31'h0, loCarry}, 32'h0000_0001);
        drive(5'h00, 16'h0000, 16'h0000);
        chk({16'h0000, accValue}, 32'h0000_FFFF);
        chk({16'h0000, loAcc}, 32'h0000_0000);
        chk({16'h0000, hiWord}, 32'h0000_FFFF);
    endtask : t_sub

    task automatic t_sreset();
        drive(5'h1F, 16'h1234, 16'h0001);
        chk({30'h0, carryOut, signedOverflow}, 32'h0000_0000);
        drive(5'h00, 16'h0000, 16'h0000);
        chk({16'h0000, accValue}, 32'h0000_0000);
    endtask : t_sreset

    task automatic t_axi();
        axiRd(STATUS_OFS, 32'h0008_0000, RESP_OKAY);
        axiWr(LOADVAL_OFS, 32'h1234_ABCD, RESP_OKAY);
        axiRd(LOADVAL_OFS, 32'h0000_ABCD, RESP_OKAY);
        axiWr(CTRL_OFS, 32'h0000_0002, RESP_OKAY);
        drive(5'h00, 16'h0000, 16'h0000);
        chk({16'h0000, accValue}, 32'h0000_ABCD);
        // Freeze must block an enabled step
        axiWr(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
        drive(5'h07, 16'h0000, 16'h0001);
        drive(5'h00, 16'h0000, 16'h0000);
        chk({16'h0000, accValue}, 32'h0000_ABCD);
        axiWr(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
        axiRd(4'hC, 32'h0000_0000, RESP_SLVERR);
        axiWr(4'hC, 32'h0000_0001, RESP_SLVERR);
    endtask : t_axi

    task automatic t_arst();
        drive(5'h07, 16'h0000, 16'h0001);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        @(negedge ref_clk);
        chk({16'h0000, accValue}, 32'h0000_0000);
        chk({30'h0, carryOut, signedOverflow}, 32'h0000_0000);
        @(posedge ref_clk);
        arst_n <= 1'b1;
    endtask : t_arst

    // ----------------
    // Main sequence
    // ----------------
    initial
    begin
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_add();
        t_sub();
        t_sreset();
        t_axi();
        t_arst();
        print_verdict();
    end
endmodule : test_loadable_accumulator_16bit
